// [cw_pkg.sv]
// Purpose: shared constants and carriers for the option and watchdog block
// Assumes: mclk is the oscillator clock, so cycle figures are mclk cycles
// Notes:   register offsets, field layouts, reset values and timing counts
package cw_pkg;

  // register addresses on the plain register port
  localparam logic [15:0] PIN_CLOCK_OPT_ADDR = 16'h001E;
  localparam logic [15:0] SYSTEM_OPT_ADDR    = 16'h001F;
  localparam logic [15:0] SERVICE_ADDR       = 16'hFFFF;

  // system option register, bit 7 down to bit 0
  typedef struct packed {
    logic watchdog_rate_select;
    logic voltage_monitor_in_stop;
    logic voltage_monitor_reset_disable;
    logic voltage_monitor_power_disable;
    logic voltage_monitor_trip_select;
    logic short_recovery;
    logic stop_enable;
    logic watchdog_disable;
  } cw_sys_opt_t;

  // pin and clock option register, bit 7 down to bit 0
  typedef struct packed {
    logic       irq_pullup_disable;
    logic       irq_pin_enable;
    logic [1:0] spare;
    logic       timer_two_position;
    logic       serial_baud_source;
    logic       oscillator_in_stop;
    logic       reset_pin_enable;
  } cw_pin_opt_t;

  // reset values and the bits that only power-on reset clears
  localparam logic [7:0] SYS_OPT_RESET    = 8'h00;
  localparam logic [7:0] PIN_OPT_RESET    = 8'h00;
  localparam logic [7:0] SYS_OPT_KEEP     = 8'h08;
  localparam logic [7:0] PIN_OPT_KEEP     = 8'h01;
  localparam logic [7:0] PIN_OPT_WRITABLE = 8'hCF;

  // prescaler stages kept by a service write (stages 12-5 are cleared)
  localparam logic [11:0] PRESC_SERVICE_KEEP = 12'h00F;

  // timing counts in oscillator cycles
  localparam int unsigned WDOG_LONG_CYCLES  = 262128;
  localparam int unsigned WDOG_SHORT_CYCLES = 8176;
  localparam logic [12:0] STOP_SHORT_CYCLES = 13'h0020;
  localparam logic [12:0] STOP_LONG_CYCLES  = 13'h1000;
  localparam logic [5:0]  PIN_PULSE_CYCLES  = 6'h20;
  localparam logic [12:0] POR_CLEAR_CYCLES  = 13'h1000;

  // stop sequencing states
  typedef enum logic [1:0] {
    CW_RUN,
    CW_STOPPED,
    CW_RECOVER
  } cw_stop_state_t;

  // controls steered by the pin and clock options
  typedef struct packed {
    logic irq_pullup_connect;
    logic irq_request_active;
    logic timer_on_high_pins;
    logic baud_from_bus_clock;
    logic reset_pin_function;
  } cw_pin_ctl_t;

  // controls for the low-voltage monitor
  typedef struct packed {
    logic powered;
    logic run_in_stop;
    logic reset_request;
    logic trip_high_supply;
  } cw_monitor_ctl_t;

  // stop sequencing outputs
  typedef struct packed {
    logic stop_accepted;
    logic illegal_opcode;
    logic cpu_stopped;
    logic clock_source_enable;
  } cw_stop_ctl_t;

endpackage

// [cw_config_watchdog.sv]
// Purpose: write-once option registers plus watchdog and stop sequencing
// Assumes: bus, stop and wake inputs come from logic on mclk
// Notes:   power_on_resetn clears all but the synchronisers, resetn spares survivor bits
//
// Contract
// - one write per option register per reset
// - option registers readable at any time
// - reset pin enable cleared only by power-on
// - trip select cleared only by power-on
// - pullup and irq function follow options
// - timer position picks high or low pins
// - baud source picks bus or oscillator clock
// - oscillator option keeps clock during stop
// - reset pin function follows its enable
// - timeout 8176 or 262128 cycles by rate
// - monitor in stop needs enable and power
// - monitor reset suppressed by disable option
// - monitor power removed by power disable
// - trip select picks high or low supply
// - stop exit after 32 or 4096 cycles
// - monitor reset exit always long recovery
// - stop illegal unless stop enabled
// - watchdog off when disable option set
// - 6-bit counter after 12-bit prescaler, overflow resets
// - service read gives vector low byte
// - watchdog reset pulses pin 32 cycles, flags
// - stop clears prescaler, internal reset clears both
// - prescaler cleared 4096 cycles after power-up
// - watchdog off in monitor mode with test voltage
`timescale 1ns/10ps

module cw_config_watchdog #(
  parameter int unsigned WDOG_LONG_CYCLES  = cw_pkg::WDOG_LONG_CYCLES,
  parameter int unsigned WDOG_SHORT_CYCLES = cw_pkg::WDOG_SHORT_CYCLES
) (
  input  wire logic                   mclk,
  input  wire logic                   resetn,
  input  wire logic                   power_on_resetn,
  input  wire logic [15:0]            addr,
  input  wire logic [7:0]             wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic [7:0]                  rdata,
  input  wire logic [7:0]             reset_vector_low,
  input  wire logic                   stop_execute,
  input  wire logic                   stop_wake,
  input  wire logic                   monitor_mode,
  input  wire logic                   irq_test_voltage,
  input  wire logic                   voltage_monitor_trip,
  output cw_pkg::cw_sys_opt_t         system_option_reg,
  output cw_pkg::cw_pin_opt_t         pin_clock_option_reg,
  output cw_pkg::cw_pin_ctl_t         pin_ctl,
  output cw_pkg::cw_monitor_ctl_t     monitor_ctl,
  output cw_pkg::cw_stop_ctl_t        stop_ctl,
  output logic                        watchdog_reset,
  output logic                        watchdog_status_set,
  output logic                        reset_pin_out,
  output logic                        reset_pin_oe
);

  localparam logic [17:0] LONG_LAST  = 18'(WDOG_LONG_CYCLES - 1);
  localparam logic [17:0] SHORT_LAST = 18'(WDOG_SHORT_CYCLES - 1);

  logic                   sys_written;
  logic                   pin_written;
  logic [11:0]            prescaler;
  logic [5:0]             wdog_count;
  logic [17:0]            elapsed;
  logic                   wdog_run;
  logic                   wdog_fire;
  logic [5:0]             pin_pulse_count;
  logic [12:0]            por_count;
  logic [12:0]            recov_count;
  cw_pkg::cw_stop_state_t stop_state;
  logic [1:0]             test_sync;
  logic [1:0]             trip_sync;
  logic                   sys_wr;
  logic                   pin_wr;
  logic                   service_wr;
  logic                   por_clear;
  logic                   monitor_resets;
  logic                   stop_accepted_q;
  logic                   illegal_opcode_q;

  // address decode
  assign sys_wr     = wr && (addr == cw_pkg::SYSTEM_OPT_ADDR);
  assign pin_wr     = wr && (addr == cw_pkg::PIN_CLOCK_OPT_ADDR);
  assign service_wr = wr && (addr == cw_pkg::SERVICE_ADDR);

  // two-stage synchronisers for analog and pin levels
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      test_sync <= 2'h0;
      trip_sync <= 2'h0;
    end
    else
    begin
      test_sync <= {test_sync[0], irq_test_voltage};
      trip_sync <= {trip_sync[0], voltage_monitor_trip};
    end
  end

  // write-once tracking, rearmed by any reset
  always_ff @(posedge mclk)
  begin
    if (!resetn || !power_on_resetn)
    begin
      sys_written <= 1'b0;
      pin_written <= 1'b0;
    end
    else
    begin
      if (sys_wr)
        sys_written <= 1'b1;
      if (pin_wr)
        pin_written <= 1'b1;
    end
  end

  // system options: trip select survives non-power-on resets
  always_ff @(posedge mclk)
  begin
    if (!power_on_resetn)
      system_option_reg <= cw_pkg::SYS_OPT_RESET;
    else if (!resetn)
      system_option_reg <= (system_option_reg & cw_pkg::SYS_OPT_KEEP)
                         | (cw_pkg::SYS_OPT_RESET & ~cw_pkg::SYS_OPT_KEEP);
    else if (sys_wr && !sys_written)
      system_option_reg <= wdata;
  end

  // pin options: reset pin enable survives non-power-on resets
  always_ff @(posedge mclk)
  begin
    if (!power_on_resetn)
      pin_clock_option_reg <= cw_pkg::PIN_OPT_RESET;
    else if (!resetn)
      pin_clock_option_reg <= (pin_clock_option_reg & cw_pkg::PIN_OPT_KEEP)
                            | (cw_pkg::PIN_OPT_RESET & ~cw_pkg::PIN_OPT_KEEP);
    else if (pin_wr && !pin_written)
      pin_clock_option_reg <= wdata & cw_pkg::PIN_OPT_WRITABLE;
  end

  // read port, data valid only in the cycle after the strobe
  always_ff @(posedge mclk)
  begin
    if (!resetn || !power_on_resetn)
      rdata <= 8'h00;
    else if (rd)
    begin
      case (addr)
        cw_pkg::SYSTEM_OPT_ADDR:    rdata <= system_option_reg;
        cw_pkg::PIN_CLOCK_OPT_ADDR: rdata <= pin_clock_option_reg;
        cw_pkg::SERVICE_ADDR:       rdata <= reset_vector_low;
        default:                    rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end

  // option-steered controls
  assign pin_ctl.irq_pullup_connect  = !pin_clock_option_reg.irq_pullup_disable;
  assign pin_ctl.irq_request_active  = pin_clock_option_reg.irq_pin_enable;
  assign pin_ctl.timer_on_high_pins  = pin_clock_option_reg.timer_two_position;
  assign pin_ctl.baud_from_bus_clock = pin_clock_option_reg.serial_baud_source;
  assign pin_ctl.reset_pin_function  = pin_clock_option_reg.reset_pin_enable;

  // low-voltage monitor controls
  assign monitor_resets = trip_sync[1] && monitor_ctl.powered
                       && !system_option_reg.voltage_monitor_reset_disable;
  assign monitor_ctl.powered = !system_option_reg.voltage_monitor_power_disable
                            && (!stop_ctl.cpu_stopped
                                || monitor_ctl.run_in_stop);
  assign monitor_ctl.run_in_stop = system_option_reg.voltage_monitor_in_stop
                    && !system_option_reg.voltage_monitor_power_disable;
  assign monitor_ctl.reset_request = monitor_resets;
  assign monitor_ctl.trip_high_supply =
    system_option_reg.voltage_monitor_trip_select;

  // stop sequencing outputs
  assign stop_ctl.stop_accepted  = stop_accepted_q;
  assign stop_ctl.illegal_opcode = illegal_opcode_q;
  assign stop_ctl.cpu_stopped = (stop_state != cw_pkg::CW_RUN);
  assign stop_ctl.clock_source_enable = (stop_state != cw_pkg::CW_STOPPED)
    || pin_clock_option_reg.oscillator_in_stop;

  // stop entry, wait for wake, then recovery delay
  always_ff @(posedge mclk)
  begin
    if (!resetn || !power_on_resetn)
    begin
      stop_state              <= cw_pkg::CW_RUN;
      recov_count             <= 13'h0000;
      stop_accepted_q         <= 1'b0;
      illegal_opcode_q        <= 1'b0;
    end
    else
    begin
      stop_accepted_q  <= 1'b0;
      illegal_opcode_q <= 1'b0;
      case (stop_state)
        cw_pkg::CW_RUN:
        begin
          if (stop_execute && system_option_reg.stop_enable)
          begin
            stop_state             <= cw_pkg::CW_STOPPED;
            stop_accepted_q <= 1'b1;
          end
          else if (stop_execute)
            illegal_opcode_q <= 1'b1;
        end
        cw_pkg::CW_STOPPED:
        begin
          if (monitor_resets)
          begin
            stop_state  <= cw_pkg::CW_RECOVER;
            recov_count <= cw_pkg::STOP_LONG_CYCLES;
          end
          else if (stop_wake)
          begin
            stop_state  <= cw_pkg::CW_RECOVER;
            recov_count <= system_option_reg.short_recovery
                         ? cw_pkg::STOP_SHORT_CYCLES
                         : cw_pkg::STOP_LONG_CYCLES;
          end
        end
        cw_pkg::CW_RECOVER:
        begin
          if (recov_count == 13'h0001)
            stop_state <= cw_pkg::CW_RUN;
          recov_count <= recov_count - 13'h0001;
        end
        default:
          stop_state <= cw_pkg::CW_RUN;
      endcase
    end
  end

  // power-up delay that clears the prescaler once
  always_ff @(posedge mclk)
  begin
    if (!power_on_resetn)
      por_count <= 13'h0000;
    else if (por_count != cw_pkg::POR_CLEAR_CYCLES)
      por_count <= por_count + 13'h0001;
  end

  assign por_clear = (por_count == cw_pkg::POR_CLEAR_CYCLES - 13'h0001);

  // watchdog runs unless disabled, in test monitor mode, or stopped
  assign wdog_run = !system_option_reg.watchdog_disable
                 && !(monitor_mode && test_sync[1])
                 && (stop_state != cw_pkg::CW_STOPPED);
  assign elapsed  = {wdog_count, prescaler};
  assign wdog_fire = wdog_run
    && (elapsed == (system_option_reg.watchdog_rate_select
                    ? SHORT_LAST : LONG_LAST));

  // prescaler: clocks the watchdog counter on each wrap
  always_ff @(posedge mclk)
  begin
    if (!resetn || !power_on_resetn)
      prescaler <= 12'h000;
    else if (por_clear || stop_ctl.stop_accepted || wdog_fire)
      prescaler <= 12'h000;
    else if (service_wr)
      prescaler <= prescaler & cw_pkg::PRESC_SERVICE_KEEP;
    else if (stop_state != cw_pkg::CW_STOPPED)
      prescaler <= prescaler + 12'h001;
  end

  // free-running 6-bit watchdog counter
  always_ff @(posedge mclk)
  begin
    if (!resetn || !power_on_resetn)
      wdog_count <= 6'h00;
    else if (service_wr || wdog_fire)
      wdog_count <= 6'h00;
    else if (stop_state != cw_pkg::CW_STOPPED && prescaler == 12'hFFF)
      wdog_count <= wdog_count + 6'h01;
  end

  // overflow pulses: system reset request and status flag
  always_ff @(posedge mclk)
  begin
    if (!resetn || !power_on_resetn)
    begin
      watchdog_reset      <= 1'b0;
      watchdog_status_set <= 1'b0;
    end
    else
    begin
      watchdog_reset      <= wdog_fire;
      watchdog_status_set <= wdog_fire;
    end
  end

  // reset pin pulse outlives the internal reset it causes
  always_ff @(posedge mclk)
  begin
    if (!power_on_resetn)
      pin_pulse_count <= 6'h00;
    else if (wdog_fire && resetn && pin_clock_option_reg.reset_pin_enable)
      pin_pulse_count <= cw_pkg::PIN_PULSE_CYCLES;
    else if (pin_pulse_count != 6'h00)
      pin_pulse_count <= pin_pulse_count - 6'h01;
  end

  // open-drain: only ever drives low
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe  = (pin_pulse_count != 6'h00);

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn || !power_on_resetn);

  sequence s_short_wake;
    stop_state == cw_pkg::CW_STOPPED && stop_wake && !monitor_resets
      && system_option_reg.short_recovery;
  endsequence

  sequence s_short_exit;
    ##31 (stop_state == cw_pkg::CW_RECOVER) ##1 (stop_state == cw_pkg::CW_RUN);
  endsequence

  sequence s_pin_fire;
    wdog_fire && pin_clock_option_reg.reset_pin_enable;
  endsequence

  property p_first_write;
    sys_wr && !sys_written |=> system_option_reg == $past(wdata);
  endproperty
  a_first_write: assert property (p_first_write)
    else $error("first option write not taken");

  property p_write_once;
    sys_wr && sys_written |=> $stable(system_option_reg);
  endproperty
  a_write_once: assert property (p_write_once)
    else $error("second option write changed register");

  property p_read_opt;
    rd && addr == cw_pkg::PIN_CLOCK_OPT_ADDR && !pin_wr
      |=> rdata == $past(pin_clock_option_reg);
  endproperty
  a_read_opt: assert property (p_read_opt)
    else $error("option read data wrong");

  property p_service_read;
    rd && addr == cw_pkg::SERVICE_ADDR
      |=> rdata == $past(reset_vector_low) && !$past(service_wr);
  endproperty
  a_service_read: assert property (p_service_read)
    else $error("service read data wrong");

  property p_service_clear;
    service_wr && stop_state != cw_pkg::CW_STOPPED
      |=> wdog_count == 6'h00 && prescaler[11:4] == 8'h00;
  endproperty
  a_service_clear: assert property (p_service_clear)
    else $error("service write did not clear watchdog");

  property p_timeout;
    wdog_fire |-> elapsed == (system_option_reg.watchdog_rate_select
                              ? SHORT_LAST : LONG_LAST);
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("watchdog fired at wrong count");

  property p_disabled;
    system_option_reg.watchdog_disable |-> !wdog_fire;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("disabled watchdog fired");

  property p_pin_pulse;
    @(posedge mclk) disable iff (!power_on_resetn)
    s_pin_fire and resetn |=> reset_pin_oe ##31 reset_pin_oe ##1 !reset_pin_oe;
  endproperty
  a_pin_pulse: assert property (p_pin_pulse)
    else $error("reset pin pulse length wrong");

  property p_illegal_stop;
    stop_execute && stop_state == cw_pkg::CW_RUN
      && !system_option_reg.stop_enable
      |=> stop_ctl.illegal_opcode && stop_state == cw_pkg::CW_RUN;
  endproperty
  a_illegal_stop: assert property (p_illegal_stop)
    else $error("disabled stop not flagged illegal");

  property p_short_recovery;
    s_short_wake |=> s_short_exit;
  endproperty
  a_short_recovery: assert property (p_short_recovery)
    else $error("short recovery length wrong");

  property p_monitor_long;
    stop_state == cw_pkg::CW_STOPPED && monitor_resets
      |=> recov_count == cw_pkg::STOP_LONG_CYCLES;
  endproperty
  a_monitor_long: assert property (p_monitor_long)
    else $error("monitor exit not long recovery");

  property p_monitor_reset;
    system_option_reg.voltage_monitor_reset_disable
      |-> !monitor_ctl.reset_request;
  endproperty
  a_monitor_reset: assert property (p_monitor_reset)
    else $error("disabled monitor reset asserted");

endmodule // cw_config_watchdog

// [cw_config_watchdog_tb.sv]
// Purpose: self-checking bench for the option and watchdog block
// Assumes: watchdog counts shortened through the top parameters
// Notes:   random options from a fixed seed, expectations from cw_pkg
`timescale 1ns/10ps

module cw_config_watchdog_tb;
  localparam int LONG_N  = 200;
  localparam int SHORT_N = 40;
  localparam int LIMIT   = 20000;

  logic                    mclk;
  logic                    resetn;
  logic                    power_on_resetn;
  logic [15:0]             addr;
  logic [7:0]              wdata;
  logic                    wr;
  logic                    rd;
  logic [7:0]              rdata;
  logic [7:0]              vec;
  logic                    stop_execute;
  logic                    stop_wake;
  logic                    monitor_mode;
  logic                    irq_test_voltage;
  logic                    trip;
  cw_pkg::cw_sys_opt_t     sys_q;
  cw_pkg::cw_pin_opt_t     pin_q;
  cw_pkg::cw_pin_ctl_t     pin_ctl;
  cw_pkg::cw_monitor_ctl_t mon_ctl;
  cw_pkg::cw_stop_ctl_t    stop_ctl;
  logic                    wd_rst;
  logic                    wd_stat;
  logic                    pin_out;
  logic                    pin_oe;
  int                      error_cnt = 0;
  int                      samples_checked = 0;
  int                      cyc = 0;
  int                      fires = 0;
  int                      oe_cyc = 0;
  int                      ill_cnt = 0;
  int                      acc_cnt = 0;

  cw_config_watchdog #(
    .WDOG_LONG_CYCLES  (LONG_N),
    .WDOG_SHORT_CYCLES (SHORT_N)
  ) i_cw_config_watchdog (
    .mclk                 (mclk),
    .resetn               (resetn),
    .power_on_resetn      (power_on_resetn),
    .addr                 (addr),
    .wdata                (wdata),
    .wr                   (wr),
    .rd                   (rd),
    .rdata                (rdata),
    .reset_vector_low     (vec),
    .stop_execute         (stop_execute),
    .stop_wake            (stop_wake),
    .monitor_mode         (monitor_mode),
    .irq_test_voltage     (irq_test_voltage),
    .voltage_monitor_trip (trip),
    .system_option_reg    (sys_q),
    .pin_clock_option_reg (pin_q),
    .pin_ctl              (pin_ctl),
    .monitor_ctl          (mon_ctl),
    .stop_ctl             (stop_ctl),
    .watchdog_reset       (wd_rst),
    .watchdog_status_set  (wd_stat),
    .reset_pin_out        (pin_out),
    .reset_pin_oe         (pin_oe)
  );

  // 125 MHz clock
  initial mclk = 1'b0;
  always #4 mclk = ~mclk;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // event counters and hang guard
  always @(posedge mclk)
  begin
    cyc++;
    if (wd_rst === 1'b1) fires++;
    if (wd_rst === 1'b1) chk("status_set", 1, wd_stat);
    if (pin_oe === 1'b1) oe_cyc++;
    if (stop_ctl.illegal_opcode === 1'b1) ill_cnt++;
    if (stop_ctl.stop_accepted === 1'b1) acc_cnt++;
    if (cyc > LIMIT)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic do_reset(input logic por);
    @(posedge mclk);
    resetn          <= 1'b0;
    power_on_resetn <= !por;
    repeat (4) @(posedge mclk);
    resetn          <= 1'b1;
    power_on_resetn <= 1'b1;
    #1;
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic cfg(input logic por, input logic [7:0] s,
                     input logic [7:0] p);
    do_reset(por);
    wr_reg(cw_pkg::SYSTEM_OPT_ADDR, s);
    wr_reg(cw_pkg::PIN_CLOCK_OPT_ADDR, p);
  endtask

  // steered controls against the expected option values
  task automatic chk_ctl(input logic [7:0] s, input logic [7:0] p,
                         input logic t);
    cw_pkg::cw_sys_opt_t so;
    cw_pkg::cw_pin_opt_t po;
    so = s;
    po = p;
    chk("pullup", !po.irq_pullup_disable, pin_ctl.irq_pullup_connect);
    chk("irq_fn", po.irq_pin_enable, pin_ctl.irq_request_active);
    chk("tmr_pos", po.timer_two_position, pin_ctl.timer_on_high_pins);
    chk("baud", po.serial_baud_source, pin_ctl.baud_from_bus_clock);
    chk("rst_fn", po.reset_pin_enable, pin_ctl.reset_pin_function);
    chk("mon_pwr", !so.voltage_monitor_power_disable, mon_ctl.powered);
    chk("mon_stop", so.voltage_monitor_in_stop
        & !so.voltage_monitor_power_disable, mon_ctl.run_in_stop);
    chk("mon_rst", t & !so.voltage_monitor_power_disable
        & !so.voltage_monitor_reset_disable, mon_ctl.reset_request);
    chk("trip_hi", so.voltage_monitor_trip_select,
        mon_ctl.trip_high_supply);
  endtask

  // wait for the cpu to run again, returning the cycles taken
  task automatic wait_run(output int n);
    int t0;
    t0 = cyc;
    while (stop_ctl.cpu_stopped === 1'b1 && cyc - t0 < 6000)
    begin
      @(posedge mclk);
      #1;
    end
    n = cyc - t0;
  endtask

  task automatic stop_pulse();
    @(posedge mclk);
    stop_execute <= 1'b1;
    @(posedge mclk);
    stop_execute <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  // main sequence
  initial
  begin
    logic [7:0] s, p, s2, p2, d;
    logic       t;
    int         t0, f0, o0, n;
    resetn = 1'b0;
    power_on_resetn = 1'b0;
    addr = 16'h0000;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    stop_execute = 1'b0;
    stop_wake = 1'b0;
    monitor_mode = 1'b0;
    irq_test_voltage = 1'b0;
    trip = 1'b0;
    void'($urandom(55));
    vec = $urandom;
    do_reset(1'b1);
    rd_reg(cw_pkg::SYSTEM_OPT_ADDR, d);
    chk("sys_unwritten", cw_pkg::SYS_OPT_RESET, d);
    rd_reg(16'h0040, d);
    chk("unmapped", 0, d);
    // write-once options with random values, both reset kinds
    repeat (6)
    begin
      s = $urandom;
      p = $urandom;
      s2 = $urandom;
      p2 = $urandom;
      t = $urandom;
      @(posedge mclk);
      trip <= t;
      cfg(1'b1, s, p);
      rd_reg(cw_pkg::SYSTEM_OPT_ADDR, d);
      chk("sys", s, d);
      rd_reg(cw_pkg::PIN_CLOCK_OPT_ADDR, d);
      chk("pin", p & cw_pkg::PIN_OPT_WRITABLE, d);
      wr_reg(cw_pkg::SYSTEM_OPT_ADDR, s2);
      wr_reg(cw_pkg::PIN_CLOCK_OPT_ADDR, p2);
      rd_reg(cw_pkg::SYSTEM_OPT_ADDR, d);
      chk("sys_again", s, d);
      rd_reg(cw_pkg::PIN_CLOCK_OPT_ADDR, d);
      chk("pin_again", p & cw_pkg::PIN_OPT_WRITABLE, d);
      chk("sys_port", s, sys_q);
      chk_ctl(s, p & cw_pkg::PIN_OPT_WRITABLE, t);
      do_reset(1'b0);
      rd_reg(cw_pkg::SYSTEM_OPT_ADDR, d);
      chk("sys_kept", s & cw_pkg::SYS_OPT_KEEP, d);
      rd_reg(cw_pkg::PIN_CLOCK_OPT_ADDR, d);
      chk("pin_kept", p & cw_pkg::PIN_OPT_KEEP, d);
      wr_reg(cw_pkg::SYSTEM_OPT_ADDR, s2);
      rd_reg(cw_pkg::SYSTEM_OPT_ADDR, d);
      chk("sys_rewrite", s2, d);
    end
    @(posedge mclk);
    trip <= 1'b0;
    // timeout per rate, service reads, pin pulse only when enabled
    for (int r = 0; r < 2; r++)
    begin
      cfg(1'b1, {r[0], 7'h00}, {7'h00, r[0]});
      wr_reg(cw_pkg::SERVICE_ADDR, 8'h5A);
      t0 = cyc;
      f0 = fires;
      o0 = oe_cyc;
      repeat (3)
      begin
        rd_reg(cw_pkg::SERVICE_ADDR, d);
        chk("vector_low", vec, d);
      end
      while (fires == f0 && cyc - t0 < 300) @(posedge mclk);
      #1;
      n = r ? SHORT_N : LONG_N;
      chk("wd_period", 1, (cyc - t0 <= n + 2) && (cyc - t0 + 17 >= n));
      repeat (34) @(posedge mclk);
      #1;
      chk("pin_low_len", r ? 32 : 0, oe_cyc - o0);
      chk("pin_level", 0, pin_out);
    end
    // regular service keeps the short watchdog quiet
    cfg(1'b1, 8'h80, 8'h00);
    f0 = fires;
    repeat (10)
    begin
      wr_reg(cw_pkg::SERVICE_ADDR, $urandom);
      repeat (20) @(posedge mclk);
    end
    chk("serviced", f0, fires);
    cfg(1'b1, 8'h81, 8'h00);
    f0 = fires;
    repeat (300) @(posedge mclk);
    chk("wd_disabled", f0, fires);
    @(posedge mclk);
    monitor_mode <= 1'b1;
    irq_test_voltage <= 1'b1;
    cfg(1'b1, 8'h80, 8'h00);
    f0 = fires;
    repeat (300) @(posedge mclk);
    chk("wd_monitor", f0, fires);
    monitor_mode <= 1'b0;
    irq_test_voltage <= 1'b0;
    // counters ran on while gated, so service before expecting a fire
    wr_reg(cw_pkg::SERVICE_ADDR, 8'h00);
    repeat (60) @(posedge mclk);
    chk("wd_resumes", 1, fires > f0);
    // stop refused, then accepted with short and monitor recovery
    cfg(1'b1, 8'h01, 8'h00);
    stop_pulse();
    chk("illegal", 1, ill_cnt);
    chk("not_stopped", 0, stop_ctl.cpu_stopped);
    cfg(1'b1, 8'h47, 8'h00);
    stop_pulse();
    chk("accepted", 1, acc_cnt);
    chk("clk_off", 0, stop_ctl.clock_source_enable);
    chk("mon_in_stop", 1, mon_ctl.powered & mon_ctl.run_in_stop);
    @(posedge mclk);
    stop_wake <= 1'b1;
    @(posedge mclk);
    stop_wake <= 1'b0;
    #1;
    wait_run(n);
    chk("short_exit", 1, n >= 30 && n <= 35);
    stop_pulse();
    @(posedge mclk);
    trip <= 1'b1;
    #1;
    wait_run(n);
    chk("monitor_exit", 1, n >= 4090 && n <= 4104);
    trip <= 1'b0;
    // long recovery by wake, oscillator kept running in stop
    cfg(1'b1, 8'h43, 8'h02);
    stop_pulse();
    chk("clk_kept", 1, stop_ctl.clock_source_enable);
    @(posedge mclk);
    stop_wake <= 1'b1;
    @(posedge mclk);
    stop_wake <= 1'b0;
    #1;
    wait_run(n);
    chk("long_exit", 1, n >= 4090 && n <= 4104);
    tally_and_finish();
  end

endmodule // cw_config_watchdog_tb
